// >>> cgc_pkg.sv
package cgc_pkg;
   localparam int CLK_MHZ = 40;
   localparam int CNT_W = 16;
   localparam int OFF_W = 20;
   localparam int TEMP_W = 9;
   // Address map
   localparam logic [6:0] A_RAM_TOP = 7'h1f;
   localparam logic [6:0] A_FLASH_TOP = 7'h5f;
   localparam logic [6:0] A_TEMP_LO = 7'h60;
   localparam logic [6:0] A_TEMP_HI = 7'h61;
   localparam logic [6:0] A_FLASH_COMMAND_REG = 7'h62;
   localparam logic [6:0] A_CNT_CLEAR = 7'h63;
   localparam logic [6:0] A_MODE = 7'h64;
   localparam logic [6:0] A_CHG_TIME_LO = 7'h65;
   localparam logic [6:0] A_CHG_TIME_HI = 7'h66;
   localparam logic [6:0] A_DSG_TIME_LO = 7'h67;
   localparam logic [6:0] A_DSG_TIME_HI = 7'h68;
   localparam logic [6:0] A_SELF_LO = 7'h69;
   localparam logic [6:0] A_SELF_HI = 7'h6a;
   localparam logic [6:0] A_CHG_CNT_LO = 7'h6b;
   localparam logic [6:0] A_CHG_CNT_HI = 7'h6c;
   localparam logic [6:0] A_DSG_CNT_LO = 7'h6d;
   localparam logic [6:0] A_DSG_CNT_HI = 7'h6e;
   localparam logic [6:0] A_PROG_DATA = 7'h6f;
   localparam logic [6:0] A_PROG_ADDR = 7'h70;
   localparam logic [6:0] A_OFF_LO = 7'h75;
   localparam logic [6:0] A_OFF_MID = 7'h76;
   localparam logic [6:0] A_OFF_HI = 7'h77;
   localparam logic [6:0] A_ID_BASE = 7'h78;
   // Counter clear bits
   localparam int CB_DSG_CNT = 0;
   localparam int CB_CHG_CNT = 1;
   localparam int CB_SELF = 2;
   localparam int CB_DSG_TIME = 3;
   localparam int CB_CHG_TIME = 4;
   // Mode / wake threshold bits
   localparam int MB_SHORT = 7;
   localparam int MB_REGDIS = 6;
   localparam int MB_WAKE_LSB = 1;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // Commands
   localparam logic [7:0] CMD_PROG = 8'h0f;
   localparam logic [7:0] CMD_ERASE0 = 8'h40;
   localparam logic [7:0] CMD_ERASE1 = 8'h41;
   localparam logic [7:0] CMD_ERASE2 = 8'h42;
   localparam logic [7:0] CMD_ERASE_OFF = 8'h43;
   localparam logic [7:0] CMD_RAM2FL = 8'h45;
   localparam logic [7:0] CMD_FL2RAM = 8'h48;
   localparam logic [7:0] CMD_PDOWN = 8'hf6;
   localparam logic [7:0] CMD_CALPD = 8'hf7;
   // Wake thresholds per code in microvolts, for the comparator
   localparam int WAKE_UV [8] = '{0, 3516, 1758, 1172, 879, 703, 586, 502};
   // Timing
   localparam int OFF_LSB_US = 9760;
   localparam int TIMER_TICK_US = 878900;
   localparam int CAL_TIMEOUT_S = 1278;
   localparam int SELF_PERIOD_S = 3600;
   localparam int REFRESH_S = 10;
   localparam int COUNT_NVH = 3050;
   localparam int DEF_OFF_NV = 4290;
   localparam int OFF_LSB_CYC = OFF_LSB_US * CLK_MHZ;
   localparam int TIMER_TICK_CYC = TIMER_TICK_US * CLK_MHZ;
   localparam int CAL_TIMEOUT_LSB = CAL_TIMEOUT_S * 1000000 / OFF_LSB_US;
   localparam int SELF_LSB = int'(64'(SELF_PERIOD_S) * 1000000 / OFF_LSB_US);
   localparam int REFRESH_LSB = REFRESH_S * 1000000 / OFF_LSB_US;
   localparam int DEF_OFF_LSB =
      int'(64'(COUNT_NVH) * 3600 * 1000000 / (64'(DEF_OFF_NV) * OFF_LSB_US));
   localparam logic [63:0] ID_ROM_DEF = 64'h0123_4567_89ab_cdef; // Arbitrary value
   typedef enum logic [1:0] {
      PWR_AWAKE = 2'b00, PWR_PEND = 2'b01, PWR_SLEEP = 2'b11, PWR_REFRESH = 2'b10
   } cgc_pwr_t;
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00, CAL_ARM = 2'b01, CAL_FIRST = 2'b11, CAL_MEAS = 2'b10
   } cgc_cal_t;
endpackage : cgc_pkg

// >>> cgc_sync.sv
`timescale 1ns/1ps
module cgc_sync #(
   parameter int W = 1 // Bits synchronised
) (
   input wire logic sys_clk, // Clock
   input wire logic rst_b, // Async reset, active low
   input wire logic [W-1:0] d, // Asynchronous inputs
   output logic [W-1:0] q // Synchronised outputs
);
   logic [W-1:0] meta_q;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : cgc_sync

// >>> cgc_tick.sv
`timescale 1ns/1ps
module cgc_tick #(
   parameter int W = 32 // Counter width
) (
   input wire logic sys_clk, // Clock
   input wire logic rst_b, // Async reset, active low
   input wire logic step, // Advance by one
   input wire logic [W-1:0] limit, // Steps per tick
   output logic tick // One-cycle tick
);
   logic [W-1:0] cnt_q;

   assign tick = step && (cnt_q == limit - 1'b1);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
      end else if (tick) begin
         cnt_q <= '0;
      end else if (step) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule : cgc_tick

// >>> cgc_gauge_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Sleep command plus low activity stops acquisition
// - Threshold code zero sleeps without activity check
// - Three-bit code selects wake threshold voltage
// - Asleep: periodic brief refresh of temperature
// - Any host line edge wakes device
// - Awake: five counters; asleep: self-discharge only
// - Calibration requested by bit or command
// - Calibration completion clears status bit
// - Offset is same-polarity pulse interval, 9.76ms units
// - Opposite second pulse restarts calibration
// - 21.3 minute timeout assumes default offset
// - Sense-short bit grounds sense input
// - Compensation bumps selected counter each offset period
// - Clear bits zero counters then self-clear
// - Time counter clear resets slow flag
// - Temperature is nine bits across two registers
// - 128-byte register and memory space
// - Offset-high byte field layout
// - Identity bytes read-only at top
// - Time counter rollover sets slow rate
// - Command bit 7 selects write or read
// - Reset loads page zero and offset shadow
module cgc_gauge_ctrl #(
   parameter int OFF_LSB_CYC = cgc_pkg::OFF_LSB_CYC, // Cycles per offset LSB
   parameter int TIMER_TICK_CYC = cgc_pkg::TIMER_TICK_CYC, // Cycles per time-counter step at the fast rate
   parameter logic [63:0] ID_ROM = cgc_pkg::ID_ROM_DEF // Identity bytes, arbitrary value
) (
   input wire logic sys_clk, // 40 MHz clock
   input wire logic rst_b, // Async reset, active low
   input wire logic cmd_valid, // Command byte pair received
   input wire logic [7:0] cmd_byte, // Command: write flag and address
   input wire logic [7:0] cmd_wdata, // Write data byte
   output logic [7:0] rd_data_q, // Read data byte
   output logic rd_valid_q, // Read data pulse
   input wire logic single_wire_port_in, // Host line level, async
   input wire logic conv_chg_in, // Converter charge pulse, async
   input wire logic conv_dsg_in, // Converter discharge pulse, async
   input wire logic below_thr_in, // Sense magnitude below threshold, async
   input wire logic [cgc_pkg::TEMP_W-1:0] temp_in, // Die temperature in kelvin, async
   output logic main_clock_run, // Main clock and acquisition running
   output logic asleep, // Device in sleep
   output logic sense_short, // Ground the sense input
   output logic regulator_disable, // Regulator amplifier off
   output logic [2:0] wake_threshold // Threshold code to comparator
);
   import cgc_pkg::*;

   logic [3:0] ctl_s;
   logic [TEMP_W-1:0] temp_s;
   logic line_prev_q;
   logic [1:0] settle_q;
   logic chg_prev_q;
   logic dsg_prev_q;
   logic line_edge;
   logic chg_e;
   logic dsg_e;
   logic below;
   logic wr;
   logic rd;
   logic flash_command_wr;
   logic [6:0] addr;
   logic [7:0] flash_command_q;
   logic [7:0] clear_q;
   logic [7:0] mode_q;
   logic [7:0] pdata_q;
   logic [7:0] paddr_q;
   logic [OFF_W-1:0] off_q;
   logic compensation_enable_q;
   logic calibration_request_q;
   logic calibration_status_q;
   logic offdir_q;
   logic [7:0] off_hi;
   logic [OFF_W-1:0] cal_cnt_q;
   logic cal_pol_q;
   logic cal_done;
   cgc_cal_t cal_q;
   cgc_pwr_t pwr_q;
   logic boot_q;
   logic awake;
   logic quiet;
   logic lsb_tick;
   logic tmr_tick;
   logic self_tick;
   logic refresh_tick;
   logic comp_on;
   logic comp_tick;
   logic [OFF_W-1:0] comp_q;
   logic pol_q;
   logic [1:0] conv_e;
   logic [1:0] comp_hit;
   logic [1:0] cnt_wipe;
   logic [1:0] tm_wipe;
   logic [CNT_W-1:0] self_q;
   logic [TEMP_W-1:0] temp_q;
   logic [7:0] rd_mux;
   logic [7:0] ram_mem [32];
   logic [7:0] flash_mem [96];
   logic [7:0] shadow_mem [3];

   cgc_sync #(.W(4)) u_sync_ctl (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .d({below_thr_in, conv_dsg_in, conv_chg_in, single_wire_port_in}),
      .q(ctl_s)
   );

   cgc_sync #(.W(TEMP_W)) u_sync_temp (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .d(temp_in),
      .q(temp_s)
   );

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         line_prev_q <= 1'b0;
         settle_q <= 2'b00;
         chg_prev_q <= 1'b0;
         dsg_prev_q <= 1'b0;
      end else begin
         line_prev_q <= ctl_s[0];
         settle_q <= settle_q + {1'b0, ~&settle_q};
         chg_prev_q <= ctl_s[1];
         dsg_prev_q <= ctl_s[2];
      end
   end

   // Synchroniser leaves reset low under an idle-high line; mask that first rise
   assign line_edge = (ctl_s[0] ^ line_prev_q) && (&settle_q);
   assign chg_e = ctl_s[1] & ~chg_prev_q;
   assign dsg_e = ctl_s[2] & ~dsg_prev_q;
   assign below = ctl_s[3];
   assign quiet = (wake_threshold == 3'd0) || below;

   assign addr = cmd_byte[6:0];
   assign wr = cmd_valid & cmd_byte[7];
   assign rd = cmd_valid & ~cmd_byte[7];
   assign flash_command_wr = wr && (addr == A_FLASH_COMMAND_REG);

   // Timebase derived from the system clock
   cgc_tick u_lsb (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .step(1'b1),
      .limit(OFF_LSB_CYC),
      .tick(lsb_tick)
   );

   cgc_tick u_tmr (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .step(1'b1),
      .limit(TIMER_TICK_CYC),
      .tick(tmr_tick)
   );

   cgc_tick u_self (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .step(lsb_tick),
      .limit(SELF_LSB),
      .tick(self_tick)
   );

   cgc_tick u_refresh (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .step(lsb_tick & ~awake),
      .limit(REFRESH_LSB),
      .tick(refresh_tick)
   );

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         boot_q <= 1'b1;
      end else begin
         boot_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         flash_command_q <= BYTE_RST;
         mode_q <= MODE_RST;
         pdata_q <= BYTE_RST;
         paddr_q <= BYTE_RST;
      end else if (wr) begin
         case (addr)
            A_FLASH_COMMAND_REG: flash_command_q <= cmd_wdata;
            A_MODE: mode_q <= cmd_wdata;
            A_PROG_DATA: pdata_q <= cmd_wdata;
            A_PROG_ADDR: paddr_q <= cmd_wdata;
            default: ;
         endcase
      end
   end

   // Clear bits stand for the one cycle in which the counters are zeroed
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         clear_q <= BYTE_RST;
      end else if (wr && addr == A_CNT_CLEAR) begin
         clear_q <= cmd_wdata;
      end else begin
         clear_q <= BYTE_RST;
      end
   end

   assign sense_short = mode_q[MB_SHORT];
   assign regulator_disable = mode_q[MB_REGDIS];
   assign wake_threshold = mode_q[MB_WAKE_LSB +: 3];

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwr_q <= PWR_AWAKE;
      end else begin
         case (pwr_q)
            PWR_AWAKE: begin
               if (flash_command_wr && (cmd_wdata == CMD_PDOWN || cmd_wdata == CMD_CALPD)) begin
                  pwr_q <= PWR_PEND;
               end
            end
            PWR_PEND: begin
               if (line_edge) begin
                  pwr_q <= PWR_AWAKE;
               end else if (cal_q == CAL_IDLE && !calibration_request_q && quiet) begin
                  pwr_q <= PWR_SLEEP;
               end
            end
            PWR_SLEEP: begin
               if (line_edge) begin
                  pwr_q <= PWR_AWAKE;
               end else if (refresh_tick) begin
                  pwr_q <= PWR_REFRESH;
               end
            end
            PWR_REFRESH: pwr_q <= line_edge ? PWR_AWAKE : PWR_SLEEP;
            default: pwr_q <= PWR_AWAKE;
         endcase
      end
   end

   assign awake = (pwr_q == PWR_AWAKE) || (pwr_q == PWR_PEND);
   assign main_clock_run = awake;
   assign asleep = ~awake;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         temp_q <= '0;
      end else if (awake || pwr_q == PWR_REFRESH) begin
         temp_q <= temp_s;
      end
   end

   assign cal_done = (cal_q == CAL_FIRST || cal_q == CAL_MEAS) && !(chg_e | dsg_e)
                     && (cal_cnt_q >= OFF_W'(CAL_TIMEOUT_LSB));

   // Calibration and the offset register share one process so that the
   // measured value and the host writes have a single priority order.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cal_q <= CAL_IDLE;
         cal_cnt_q <= '0;
         cal_pol_q <= 1'b0;
         off_q <= '0;
         compensation_enable_q <= 1'b0;
         calibration_request_q <= 1'b0;
         calibration_status_q <= 1'b1;
         offdir_q <= 1'b0;
      end else if (boot_q) begin
         off_q <= {shadow_mem[2][3:0], shadow_mem[1], shadow_mem[0]};
         {compensation_enable_q, calibration_status_q, offdir_q} <= {shadow_mem[2][7], shadow_mem[2][5:4]};
      end else begin
         if (lsb_tick && (cal_q == CAL_FIRST || cal_q == CAL_MEAS)) begin
            cal_cnt_q <= cal_cnt_q + 1'b1;
         end
         case (cal_q)
            CAL_IDLE: begin
               if (calibration_request_q) begin
                  cal_q <= CAL_ARM;
               end
            end
            CAL_ARM: begin
               if (quiet) begin
                  cal_q <= CAL_FIRST;
                  cal_cnt_q <= '0;
               end
            end
            CAL_FIRST: begin
               if (chg_e | dsg_e) begin
                  cal_pol_q <= chg_e;
                  cal_cnt_q <= '0;
                  cal_q <= CAL_MEAS;
               end
            end
            CAL_MEAS: begin
               if ((chg_e | dsg_e) && chg_e == cal_pol_q) begin
                  off_q <= cal_cnt_q;
                  cal_q <= CAL_IDLE;
                  calibration_request_q <= 1'b0;
                  calibration_status_q <= 1'b0;
               end else if (chg_e | dsg_e) begin
                  cal_q <= CAL_FIRST;
                  cal_cnt_q <= '0;
               end
            end
            default: cal_q <= CAL_IDLE;
         endcase
         if (cal_done) begin
            off_q <= OFF_W'(DEF_OFF_LSB);
            cal_q <= CAL_IDLE;
            calibration_request_q <= 1'b0;
            calibration_status_q <= 1'b0;
         end
         if (flash_command_wr && cmd_wdata == CMD_CALPD) begin
            calibration_request_q <= 1'b1;
            calibration_status_q <= 1'b1;
         end
         if (wr && addr == A_OFF_LO) begin
            off_q[7:0] <= cmd_wdata;
         end
         if (wr && addr == A_OFF_MID) begin
            off_q[15:8] <= cmd_wdata;
         end
         if (wr && addr == A_OFF_HI) begin
            compensation_enable_q <= cmd_wdata[7];
            offdir_q <= cmd_wdata[4];
            off_q[19:16] <= cmd_wdata[3:0];
            if (cmd_wdata[6]) begin
               calibration_request_q <= 1'b1;
               calibration_status_q <= 1'b1;
            end
         end
      end
   end

   assign off_hi = {compensation_enable_q, calibration_request_q, calibration_status_q, offdir_q, off_q[19:16]};

   // A zero offset would wrap to all ones and compensate once per 2^20 LSBs; treat it as no offset
   assign comp_on = compensation_enable_q && !calibration_status_q && awake && (off_q != '0);
   assign comp_tick = comp_on && lsb_tick && (comp_q == off_q - 1'b1);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         comp_q <= '0;
      end else if (!comp_on || comp_tick) begin
         comp_q <= '0;
      end else if (lsb_tick) begin
         comp_q <= comp_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pol_q <= 1'b0;
      end else if (chg_e) begin
         pol_q <= 1'b1;
      end else if (dsg_e) begin
         pol_q <= 1'b0;
      end
   end

   assign conv_e = {dsg_e, chg_e};
   assign comp_hit = {~offdir_q & comp_tick, offdir_q & comp_tick};
   assign cnt_wipe = {clear_q[CB_DSG_CNT], clear_q[CB_CHG_CNT]};
   assign tm_wipe = {clear_q[CB_DSG_TIME], clear_q[CB_CHG_TIME]};

   // Index 0 is the charge side, index 1 the discharge side
   for (genvar i = 0; i < 2; i++) begin : g_dir
      logic [CNT_W-1:0] cnt_q;
      logic [CNT_W-1:0] tm_q;
      logic [7:0] pre_q;
      logic slow_q;
      logic act;
      logic step;

      assign act = awake && !below && (pol_q == (i == 0)) && tmr_tick;
      assign step = act && (!slow_q || pre_q == 8'hff);

      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b) begin
            cnt_q <= '0;
         end else if (cnt_wipe[i]) begin
            cnt_q <= '0;
         end else if (awake && (conv_e[i] || comp_hit[i])) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end

      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b) begin
            tm_q <= '0;
            pre_q <= '0;
            slow_q <= 1'b0;
         end else if (tm_wipe[i]) begin
            tm_q <= '0;
            pre_q <= '0;
            slow_q <= 1'b0;
         end else begin
            if (act) begin
               pre_q <= pre_q + 1'b1;
            end
            if (step) begin
               tm_q <= tm_q + 1'b1;
               if (&tm_q) begin
                  slow_q <= 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         self_q <= '0;
      end else if (clear_q[CB_SELF]) begin
         self_q <= '0;
      end else if (self_tick) begin
         self_q <= self_q + 1'b1;
      end
   end

   // Nonvolatile arrays carry no reset; page zero is reloaded after reset
   always_ff @(posedge sys_clk) begin
      if (boot_q || (flash_command_wr && cmd_wdata == CMD_FL2RAM)) begin
         for (int i = 0; i < 32; i++) begin
            ram_mem[i] <= flash_mem[i];
         end
      end else if (wr && addr <= A_RAM_TOP) begin
         ram_mem[addr[4:0]] <= cmd_wdata;
      end
   end

   // Flash programming only clears bits; erase is the way back to ones
   always_ff @(posedge sys_clk) begin
      if (flash_command_wr) begin
         case (cmd_wdata)
            CMD_PROG: begin
               if (paddr_q[6:0] <= A_FLASH_TOP) begin
                  flash_mem[paddr_q[6:0]] <= flash_mem[paddr_q[6:0]] & pdata_q;
               end
            end
            CMD_ERASE0, CMD_ERASE1, CMD_ERASE2: begin
               for (int i = 0; i < 32; i++) begin
                  flash_mem[{cmd_wdata[1:0], 5'(i)}] <= 8'hff;
               end
            end
            CMD_ERASE_OFF: begin
               for (int i = 0; i < 3; i++) begin
                  shadow_mem[i] <= 8'hff;
               end
            end
            CMD_RAM2FL: begin
               for (int i = 0; i < 32; i++) begin
                  flash_mem[i] <= flash_mem[i] & ram_mem[i];
               end
               shadow_mem[0] <= shadow_mem[0] & off_q[7:0];
               shadow_mem[1] <= shadow_mem[1] & off_q[15:8];
               shadow_mem[2] <= shadow_mem[2] & off_hi;
            end
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      if (addr <= A_RAM_TOP) begin
         rd_mux = ram_mem[addr[4:0]];
      end else if (addr <= A_FLASH_TOP) begin
         rd_mux = flash_mem[addr];
      end else if (addr >= A_ID_BASE) begin
         rd_mux = ID_ROM[{addr[2:0], 3'b000} +: 8];
      end else begin
         case (addr)
            A_TEMP_LO: rd_mux = temp_q[7:0];
            A_TEMP_HI: rd_mux = {7'h00, temp_q[8]};
            A_FLASH_COMMAND_REG: rd_mux = flash_command_q;
            A_CNT_CLEAR: rd_mux = clear_q;
            A_MODE: rd_mux = {mode_q[7:6], g_dir[0].slow_q, g_dir[1].slow_q, mode_q[3:0]};
            A_CHG_TIME_LO: rd_mux = g_dir[0].tm_q[7:0];
            A_CHG_TIME_HI: rd_mux = g_dir[0].tm_q[15:8];
            A_DSG_TIME_LO: rd_mux = g_dir[1].tm_q[7:0];
            A_DSG_TIME_HI: rd_mux = g_dir[1].tm_q[15:8];
            A_SELF_LO: rd_mux = self_q[7:0];
            A_SELF_HI: rd_mux = self_q[15:8];
            A_CHG_CNT_LO: rd_mux = g_dir[0].cnt_q[7:0];
            A_CHG_CNT_HI: rd_mux = g_dir[0].cnt_q[15:8];
            A_DSG_CNT_LO: rd_mux = g_dir[1].cnt_q[7:0];
            A_DSG_CNT_HI: rd_mux = g_dir[1].cnt_q[15:8];
            A_PROG_DATA: rd_mux = pdata_q;
            A_PROG_ADDR: rd_mux = paddr_q;
            A_OFF_LO: rd_mux = off_q[7:0];
            A_OFF_MID: rd_mux = off_q[15:8];
            A_OFF_HI: rd_mux = off_hi;
            default: rd_mux = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_q <= 8'h00;
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= rd;
         if (rd) begin
            rd_data_q <= rd_mux;
         end
      end
   end
endmodule : cgc_gauge_ctrl

// >>> cgc_gauge_ctrl_sva.sv
`timescale 1ns/1ps
module cgc_gauge_ctrl_chk (
   input wire logic sys_clk, // Clock
   input wire logic rst_b, // Reset, active low
   input wire logic cmd_valid, // Request strobe
   input wire logic [7:0] cmd_byte, // Command
   input wire logic [7:0] cmd_wdata, // Write data
   input wire logic [7:0] rd_data_q, // Read data
   input wire logic rd_valid_q, // Read pulse
   input wire logic single_wire_port_in, // Host line
   input wire logic main_clock_run, // Awake
   input wire logic asleep, // Asleep
   input wire logic sense_short, // Sense short
   input wire logic [2:0] wake_threshold // Threshold code
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   wire rd = cmd_valid && !cmd_byte[7];
   rd_answer_a: assert property (rd |=> rd_valid_q)
      else $error("read not answered");
   no_spurious_a: assert property (!rd |=> !rd_valid_q)
      else $error("read pulse without read");
   sleep_flag_a: assert property (asleep == !main_clock_run)
      else $error("sleep flags disagree");
   short_bit_a: assert property (cmd_valid && cmd_byte == 8'he4 |=> sense_short == $past(cmd_wdata[7]))
      else $error("sense short not updated");
   thr_code_a: assert property (cmd_valid && cmd_byte == 8'he4 |=> wake_threshold == $past(cmd_wdata[3:1]))
      else $error("threshold code not updated");
   rsvd_zero_a: assert property (rd && cmd_byte[6:0] inside {[7'h71:7'h74]} |=> rd_data_q == 8'h00)
      else $error("reserved read not zero");
   wake_edge_a: assert property (asleep && $changed(single_wire_port_in) |-> ##[1:6] !asleep)
      else $error("line edge did not wake");
   sleep_enter_a: assert property (cmd_valid && cmd_byte == 8'he2 && cmd_wdata == 8'hf6 &&
      wake_threshold == 3'h0 |-> ##[1:8] asleep)
      else $error("no sleep at code zero");
endmodule : cgc_gauge_ctrl_chk
bind cgc_gauge_ctrl cgc_gauge_ctrl_chk chk_inst (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
   .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
   .single_wire_port_in(single_wire_port_in), .main_clock_run(main_clock_run), .asleep(asleep),
   .sense_short(sense_short), .wake_threshold(wake_threshold));

// >>> cgc_host_model.sv
`timescale 1ns/1ps
module cgc_host_model (
   input wire logic sys_clk, // Clock
   output logic cmd_valid, // Request strobe
   output logic [7:0] cmd_byte, // Command
   output logic [7:0] cmd_wdata, // Write data
   output logic line, // Host line, pulled up when idle
   output logic conv_chg // Converter charge pulse
);
   initial begin
      cmd_valid = 1'b0;
      cmd_byte = 8'h00;
      cmd_wdata = 8'h00;
      line = 1'b1;
      conv_chg = 1'b0;
   end
   task automatic send(input logic [7:0] c, input logic [7:0] d);
      @(posedge sys_clk);
      #2 cmd_valid = 1'b1;
      cmd_byte = c;
      cmd_wdata = d;
      @(posedge sys_clk);
      #2 cmd_valid = 1'b0;
      cmd_byte = ~c; // Released fields never keep the old value
      cmd_wdata = ~d;
   endtask : send
   task automatic nap();
      send(8'he2, 8'h45);
      send(8'he2, 8'hf6);
   endtask : nap
   task automatic poke();
      @(posedge sys_clk);
      #2 line = ~line;
   endtask : poke
   task automatic pulse();
      @(posedge sys_clk);
      #2 conv_chg = 1'b1;
      @(posedge sys_clk);
      #2 conv_chg = 1'b0;
   endtask : pulse
endmodule : cgc_host_model

// >>> cgc_gauge_ctrl_test.sv
`timescale 1ns/1ps
module cgc_gauge_ctrl_test;
   localparam logic [63:0] ID = 64'h1122_3344_5566_7788; // Arbitrary value
   logic sys_clk, rst_b, cmd_valid, swp, below, main_run, asleep, rd_valid_q, chg, regdis;
   logic [7:0] cmd_byte, cmd_wdata, rd_data_q, e, m, d;
   logic [8:0] temp;
   logic [7:0] exp_q[$], msk_q[$];
   int fail_count = 0, checked = 0;
   cgc_host_model cgc_host_model_inst (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
      .cmd_wdata(cmd_wdata), .line(swp), .conv_chg(chg));
   cgc_gauge_ctrl #(.OFF_LSB_CYC(8), .TIMER_TICK_CYC(4), .ID_ROM(ID)) cgc_gauge_ctrl_inst (.sys_clk(sys_clk),
      .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata), .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q), .single_wire_port_in(swp), .conv_chg_in(chg), .conv_dsg_in(1'b0),
      .below_thr_in(below), .temp_in(temp), .main_clock_run(main_run), .asleep(asleep), .sense_short(),
      .regulator_disable(regdis), .wake_threshold());
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic test_done();
      if (fail_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   task automatic chk(string n, logic [7:0] x, logic [7:0] y);
      checked++;
      if (x !== y) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, x, y);
      end
   endtask : chk
   task automatic rd(logic [7:0] a, logic [7:0] x, logic [7:0] mk = 8'hff);
      exp_q.push_back(x);
      msk_q.push_back(mk);
      cgc_host_model_inst.send(a, 8'h00);
   endtask : rd
   // Sampled mid-cycle so the read pulse has settled
   always @(negedge sys_clk) if (rd_valid_q === 1'b1) begin
      if (exp_q.size() == 0) chk("rd_valid_q", 8'h00, 8'h01);
      else begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         chk("rd_data_q", e & m, rd_data_q & m);
      end
   end
   initial begin
      #50000;
      fail_count++;
      test_done();
   end
   initial begin
      rst_b = 1'b0;
      below = 1'b0;
      temp = 9'h000;
      void'($urandom(32'h270bdcdc));
      repeat (6) @(posedge sys_clk);
      #2 rst_b = 1'b1;
      cgc_host_model_inst.send(8'hf7, 8'h00);
      rd(8'h77, 8'h00, 8'hdf);
      for (int a = 8'h71; a <= 8'h74; a++) begin
         cgc_host_model_inst.send(8'h80 | a[7:0], 8'($urandom));
         rd(a[7:0], 8'h00);
      end
      for (int i = 0; i < 8; i++) begin
         cgc_host_model_inst.send(8'hf8 + i[7:0], 8'h00);
         rd(8'h78 + i[7:0], ID[8*i +: 8]);
      end
      d = 8'($urandom) & 8'hce;
      cgc_host_model_inst.send(8'he4, d);
      chk("regulator_disable", {7'h00, d[6]}, {7'h00, regdis});
      cgc_host_model_inst.send(8'he3, 8'h1f);
      rd(8'h63, 8'h00);
      rd(8'h64, d, 8'hfe);
      for (int a = 8'h6b; a <= 8'h6e; a++) rd(a[7:0], 8'h00);
      temp = 9'($urandom);
      repeat (5) @(posedge sys_clk);
      rd(8'h60, temp[7:0]);
      rd(8'h61, {7'h00, temp[8]}, 8'h01);
      cgc_host_model_inst.send(8'he4, 8'h00);
      cgc_host_model_inst.send(8'hf7, 8'h40);
      cgc_host_model_inst.pulse();
      repeat (22) @(posedge sys_clk);
      cgc_host_model_inst.pulse();
      repeat (4) @(posedge sys_clk);
      rd(8'h77, 8'h00);
      rd(8'h75, 8'h02, 8'hfe);
      rd(8'h6b, 8'h02);
      cgc_host_model_inst.send(8'he4, 8'h02);
      cgc_host_model_inst.nap();
      repeat (8) @(posedge sys_clk);
      chk("asleep", 8'h00, {7'h00, asleep});
      #2 below = 1'b1;
      repeat (8) @(posedge sys_clk);
      chk("asleep", 8'h01, {7'h00, asleep});
      cgc_host_model_inst.poke();
      repeat (8) @(posedge sys_clk);
      chk("main_clock_run", 8'h01, {7'h00, main_run});
      #2 below = 1'b0;
      cgc_host_model_inst.send(8'he4, 8'h00);
      cgc_host_model_inst.nap();
      repeat (8) @(posedge sys_clk);
      chk("asleep", 8'h01, {7'h00, asleep});
      test_done();
   end
endmodule : cgc_gauge_ctrl_test
